// *** rtl/thcm_pkg.sv ***
`default_nettype none
package thcm_pkg;
  // clock and evaluation step
  localparam int CLK_MHZ = 100;
  localparam int STEP_MS = 10;
  localparam int STEP_CYCLES = STEP_MS * 1000 * CLK_MHZ;
  // discrepancy and synchronisation times in ms
  localparam int DISC_MAX_MS = 500;
  localparam int DISC_RST_MS = 30;
  localparam int SYNC_MS = 500;
  // step counts derived from the times
  localparam int TW = 6;
  localparam logic [5:0] DISC_MAX_STEPS = 6'(DISC_MAX_MS / STEP_MS);
  localparam logic [5:0] DISC_RST_STEPS = 6'(DISC_RST_MS / STEP_MS);
  localparam logic [5:0] SYNC_STEPS = 6'(SYNC_MS / STEP_MS);
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_DISC1 = 12'h004;
  localparam logic [11:0] OFF_DISC2 = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_EN = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h018;
  // control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_E1_EN = 1;
  localparam int CTRL_E2_EN = 2;
  localparam int CTRL_FP_EN = 3;
  localparam logic [3:0] CTRL_RST = 4'hF;
  // interrupt event fields
  localparam int IRQ_W = 4;
  localparam int IRQ_ERR1 = 0;
  localparam int IRQ_ERR2 = 1;
  localparam int IRQ_ON = 2;
  localparam int IRQ_SYNC = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  // enable sequencer states
  typedef enum logic [1:0] {
    ST_LOCK = 2'h0,
    ST_REL = 2'h1,
    ST_SYNC = 2'h2,
    ST_ON = 2'h3
  } thcm_state_t;
endpackage
`default_nettype wire

// *** rtl/thcm_pair_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface thcm_pair_if;
  logic tick;
  logic no;
  logic nc;
  logic clear;
  logic [thcm_pkg::TW-1:0] limit;
  logic err;
  logic released;
  logic active;
  modport chk (
    input tick,
    input no,
    input nc,
    input clear,
    input limit,
    output err,
    output released,
    output active
  );
  modport mon (
    output tick,
    output no,
    output nc,
    output clear,
    output limit,
    input err,
    input released,
    input active
  );
endinterface
`default_nettype wire

// *** rtl/thcm_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
module thcm_tick #(
  parameter int CYCLES = thcm_pkg::STEP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt_ff;
  logic tick_ff;

  if (CYCLES < 2) begin : g_chk
    $error("thcm_tick: CYCLES must be at least 2");
  end

  // free running prescaler, one pulse per evaluation step
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == W'(CYCLES - 1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick_out = tick_ff;
endmodule
`default_nettype wire

// *** rtl/thcm_pair.sv ***
`timescale 1ns/1ns
`default_nettype none
module thcm_pair (
  input wire logic clk_in,
  input wire logic rst_in,
  thcm_pair_if.chk pair
);
  localparam int TW = thcm_pkg::TW;
  logic [TW-1:0] cnt_ff;
  logic err_ff;
  logic disagree;
  logic set_err;

  // complementary contacts: equal levels mean they disagree
  assign disagree = (pair.no == pair.nc);
  assign pair.released = ~pair.no & pair.nc;
  assign pair.active = pair.no & ~pair.nc;

  // a zero limit switches the check off entirely
  assign set_err = pair.tick & disagree & (pair.limit != '0) & (cnt_ff >= pair.limit);

  // count evaluation steps spent in disagreement, saturating
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (pair.tick) begin
      if (!disagree) begin
        cnt_ff <= '0;
      end else if (cnt_ff != '1) begin
        cnt_ff <= cnt_ff + TW'(1);
      end
    end
  end

  // sticky error; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_ff <= 1'b0;
    end else if (set_err) begin
      err_ff <= 1'b1;
    end else if (pair.clear) begin
      err_ff <= 1'b0;
    end
  end

  assign pair.err = err_ff;
endmodule
`default_nettype wire

// *** rtl/thcm_two_hand.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - enable only when both hands active and timing and pattern are met
// - enable drops when a hand is inactive, timing fails or any error exists
// - per-pair discrepancy time 0 to 500 ms in 10 ms steps, default 30 ms
// - a zero discrepancy time skips that pair's check
// - enable only for both pairs NO on and NC off
// - per-pair discrepancy error outputs, each shown only when configured
// - optional fault-present output, shown only when configured
// - discrepancy error: enable off, fault set, pair error flag set
// - errors clear on both released then both active, or idle to run
// - hands not both done within 500 ms keep enable off, no error
module thcm_two_hand #(
  parameter int TICK_CYCLES = thcm_pkg::STEP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hand1_no_in,
  input wire logic hand1_nc_in,
  input wire logic hand2_no_in,
  input wire logic hand2_nc_in,
  output logic enable_out,
  output logic disc_err1_out,
  output logic disc_err2_out,
  output logic fault_out,
  output logic irq_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  localparam int CW = thcm_pkg::CTRL_W;
  localparam int IW = thcm_pkg::IRQ_W;
  localparam int TW = thcm_pkg::TW;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("thcm_two_hand: TICK_CYCLES must be at least 2");
  end

  // limit a written step count to the legal range
  function automatic logic [TW-1:0] clamp_steps(input logic [31:0] v);
    logic [TW-1:0] r;
    r = thcm_pkg::DISC_MAX_STEPS;
    if (v < 32'(thcm_pkg::DISC_MAX_STEPS)) begin
      r = v[TW-1:0];
    end
    return r;
  endfunction

  logic tick;
  logic eval_ff;
  logic [3:0] in_ff;
  logic [CW-1:0] ctrl_ff;
  logic [TW-1:0] disc1_ff;
  logic [TW-1:0] disc2_ff;
  logic run_d_ff;
  logic run_rise;
  logic clr_arm_ff;
  logic clear;
  thcm_pkg::thcm_state_t state_ff;
  thcm_pkg::thcm_state_t nxt_state;
  logic [TW-1:0] sync_cnt_ff;
  logic [TW-1:0] nxt_sync_cnt;
  logic sync_to;
  logic both_act;
  logic both_rel;
  logic fault;
  logic hold;
  logic enable_ff;
  logic [2:0] ev_d_ff;
  logic [IW-1:0] irq_stat_ff;
  logic [IW-1:0] irq_en_ff;
  logic [IW-1:0] irq_ev;
  logic [IW-1:0] irq_clr;
  logic addr_ok;
  logic wr_ff;
  logic [11:0] waddr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;

  // evaluation step generator
  thcm_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // inputs are frozen once per step, evaluation follows one clock later
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_ff <= 4'h0;
      eval_ff <= 1'b0;
    end else begin
      eval_ff <= tick;
      if (tick) begin
        in_ff <= {hand2_nc_in, hand2_no_in, hand1_nc_in, hand1_no_in};
      end
    end
  end

  thcm_pair_if p1 ();
  thcm_pair_if p2 ();

  // both checkers see the same step and the same clear
  assign p1.tick = eval_ff;
  assign p1.no = in_ff[0];
  assign p1.nc = in_ff[1];
  assign p1.clear = clear;
  assign p1.limit = disc1_ff;
  assign p2.tick = eval_ff;
  assign p2.no = in_ff[2];
  assign p2.nc = in_ff[3];
  assign p2.clear = clear;
  assign p2.limit = disc2_ff;

  thcm_pair u_pair1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pair(p1.chk)
  );

  thcm_pair u_pair2 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pair(p2.chk)
  );

  // hand state over both pairs
  assign both_act = p1.active & p2.active;
  assign both_rel = p1.released & p2.released;
  assign fault = p1.err | p2.err;
  assign hold = fault | ~ctrl_ff[thcm_pkg::CTRL_RUN];

  // leaving idle for run is one of the two ways out of an error
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_d_ff <= 1'b1;
    end else begin
      run_d_ff <= ctrl_ff[thcm_pkg::CTRL_RUN];
    end
  end
  assign run_rise = ctrl_ff[thcm_pkg::CTRL_RUN] & ~run_d_ff;

  // release of both hands arms the clear, a new press fires it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clr_arm_ff <= 1'b0;
    end else if (!fault || clear) begin
      clr_arm_ff <= 1'b0;
    end else if (eval_ff && both_rel) begin
      clr_arm_ff <= 1'b1;
    end
  end
  assign clear = run_rise | (eval_ff & clr_arm_ff & both_act);

  // enable sequencer: release, press both within the window, hold
  always_comb begin
    nxt_state = state_ff;
    nxt_sync_cnt = sync_cnt_ff;
    sync_to = 1'b0;
    case (state_ff)
      thcm_pkg::ST_LOCK: begin
        if (both_rel) begin
          nxt_state = thcm_pkg::ST_REL;
        end
      end
      thcm_pkg::ST_REL: begin
        if (both_act) begin
          nxt_state = thcm_pkg::ST_ON;
        end else if (!both_rel) begin
          nxt_state = thcm_pkg::ST_SYNC;
          nxt_sync_cnt = TW'(1);
        end
      end
      thcm_pkg::ST_SYNC: begin
        if (both_act) begin
          nxt_state = thcm_pkg::ST_ON;
        end else if (both_rel) begin
          nxt_state = thcm_pkg::ST_REL;
        end else if (sync_cnt_ff >= thcm_pkg::SYNC_STEPS) begin
          nxt_state = thcm_pkg::ST_LOCK;
          sync_to = 1'b1;
        end else begin
          nxt_sync_cnt = sync_cnt_ff + TW'(1);
        end
      end
      thcm_pkg::ST_ON: begin
        if (!both_act) begin
          nxt_state = thcm_pkg::ST_LOCK;
        end
      end
      default: begin
        nxt_state = thcm_pkg::ST_LOCK;
      end
    endcase
    // an error or idle mode forces a fresh release first
    if (hold) begin
      nxt_state = thcm_pkg::ST_LOCK;
    end
  end

  // sequencer advances only on evaluation steps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= thcm_pkg::ST_LOCK;
      sync_cnt_ff <= '0;
    end else if (eval_ff) begin
      state_ff <= nxt_state;
      sync_cnt_ff <= nxt_sync_cnt;
    end
  end

  // registered enable; pattern rechecked so no state can bypass it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_ff <= 1'b0;
    end else begin
      enable_ff <= (state_ff == thcm_pkg::ST_ON) & both_act & ~hold;
    end
  end

  // gated error and fault views
  assign enable_out = enable_ff;
  assign disc_err1_out = p1.err & ctrl_ff[thcm_pkg::CTRL_E1_EN];
  assign disc_err2_out = p2.err & ctrl_ff[thcm_pkg::CTRL_E2_EN];
  assign fault_out = fault & ctrl_ff[thcm_pkg::CTRL_FP_EN];

  // event edges for the interrupt status
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ev_d_ff <= 3'h0;
    end else begin
      ev_d_ff <= {enable_ff, p2.err, p1.err};
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[thcm_pkg::IRQ_ERR1] = p1.err & ~ev_d_ff[0];
    irq_ev[thcm_pkg::IRQ_ERR2] = p2.err & ~ev_d_ff[1];
    irq_ev[thcm_pkg::IRQ_ON] = enable_ff & ~ev_d_ff[2];
    irq_ev[thcm_pkg::IRQ_SYNC] = eval_ff & sync_to & ~hold;
  end

  // write-one-to-clear strobe, valid in the write data phase
  assign irq_clr = (wr_ff && waddr_ff == thcm_pkg::OFF_IRQ_CLR) ? hwdata_in[IW-1:0] : '0;

  // sticky status: an event in the clearing cycle survives
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
    end
  end
  assign irq_out = |(irq_stat_ff & irq_en_ff);

  // address phase capture; zero wait states, so hready is ours
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ff <= 1'b0;
      waddr_ff <= 12'h000;
    end else begin
      wr_ff <= addr_ok & hwrite_in;
      waddr_ff <= haddr_in[11:0];
    end
  end

  // register writes in the data phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= thcm_pkg::CTRL_RST;
      disc1_ff <= thcm_pkg::DISC_RST_STEPS;
      disc2_ff <= thcm_pkg::DISC_RST_STEPS;
      irq_en_ff <= thcm_pkg::IRQ_EN_RST;
    end else if (wr_ff) begin
      case (waddr_ff)
        thcm_pkg::OFF_CTRL: begin
          ctrl_ff <= hwdata_in[CW-1:0];
        end
        thcm_pkg::OFF_DISC1: begin
          disc1_ff <= clamp_steps(hwdata_in);
        end
        thcm_pkg::OFF_DISC2: begin
          disc2_ff <= clamp_steps(hwdata_in);
        end
        thcm_pkg::OFF_IRQ_EN: begin
          irq_en_ff <= hwdata_in[IW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped and write-only words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr_in[11:0])
      thcm_pkg::OFF_CTRL: begin
        rd_mux = 32'(ctrl_ff);
      end
      thcm_pkg::OFF_DISC1: begin
        rd_mux = 32'(disc1_ff);
      end
      thcm_pkg::OFF_DISC2: begin
        rd_mux = 32'(disc2_ff);
      end
      thcm_pkg::OFF_STAT: begin
        rd_mux = 32'({in_ff, state_ff, clr_arm_ff, p2.err, p1.err, enable_ff});
      end
      thcm_pkg::OFF_IRQ_STAT: begin
        rd_mux = 32'(irq_stat_ff);
      end
      thcm_pkg::OFF_IRQ_EN: begin
        rd_mux = 32'(irq_en_ff);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // read data is taken at the address phase edge, so it is registered
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_in) begin
      rdata_ff <= rd_mux;
    end
  end

  assign hrdata_out = rdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
endmodule
`default_nettype wire

// *** tb/thcm_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module thcm_props #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hand1_no_in,
  input wire logic hand1_nc_in,
  input wire logic hand2_no_in,
  input wire logic hand2_nc_in,
  input wire logic enable_out,
  input wire logic disc_err1_out,
  input wire logic disc_err2_out,
  input wire logic fault_out
);
  // worst case from an input change to the enable output
  localparam int LAT = 2 * TICK_CYCLES + 2;
  logic pat;
  // the only contact pattern that may enable
  assign pat = hand1_no_in & ~hand1_nc_in & hand2_no_in & ~hand2_nc_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_ERR1_OFF: assert property (disc_err1_out |=> !enable_out)
    else $error("enable high after pair one error");
  AST_ERR2_OFF: assert property (disc_err2_out |=> !enable_out)
    else $error("enable high after pair two error");
  AST_FAULT_OFF: assert property (fault_out |=> !enable_out)
    else $error("enable high while fault shown");
  // error views are gated on their own, so the falling fault edge is checked here and pair one's fall in AST_ERR_CLR
  AST_FAULT_SRC: assert property ($fell(fault_out) |-> !enable_out)
    else $error("fault dropped while enable high");
  AST_EN_PAT: assert property (enable_out && !pat |-> ##[1:LAT] !enable_out)
    else $error("enable kept on a wrong pattern");
  AST_EN_CLEAN: assert property ($rose(enable_out) |-> !disc_err1_out && !disc_err2_out)
    else $error("enable rose with an error present");
  AST_ERR_CLR: assert property ($fell(disc_err1_out) |-> !enable_out ##1 !enable_out)
    else $error("clearing an error enabled at once");
  // rise and fall may sit three clocks apart, so a run of two is the most
  AST_EN_STEP: assert property ($changed(enable_out) |=> $stable(enable_out) [*2])
    else $error("enable changed twice in one step");
endmodule
bind thcm_two_hand thcm_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .hand1_no_in(hand1_no_in),
  .hand1_nc_in(hand1_nc_in),
  .hand2_no_in(hand2_no_in),
  .hand2_nc_in(hand2_nc_in),
  .enable_out(enable_out),
  .disc_err1_out(disc_err1_out),
  .disc_err2_out(disc_err2_out),
  .fault_out(fault_out)
);
`default_nettype wire

// *** tb/thcm_hand_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module thcm_hand_model (
  input wire logic act1_in,
  input wire logic act2_in,
  input wire logic wrong1_in,
  input wire logic wrong2_in,
  output logic no1_out,
  output logic nc1_out,
  output logic no2_out,
  output logic nc2_out
);
  // a faulty pair has its nc contact follow no, so both read alike
  assign no1_out = act1_in;
  assign nc1_out = act1_in ~^ wrong1_in;
  assign no2_out = act2_in;
  assign nc2_out = act2_in ~^ wrong2_in;
endmodule
`default_nettype wire

// *** tb/two_hand_control_monitor_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module two_hand_control_monitor_tb;
  localparam int TICK = 4;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic a1 = 1'h0, a2 = 1'h0, w1 = 1'h0, w2 = 1'h0;
  logic n1, c1, n2, c2, en, e1, e2, flt, irq, hrdy, hresp;
  logic hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  int n_errors = 0, checks_done = 0;
  // rows are {act1, wrong1, act2, wrong2, expected enable}
  logic [4:0] rows [16] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E,
    5'h10, 5'h12, 5'h15, 5'h16, 5'h18, 5'h1A, 5'h1C, 5'h1E};
  always #5 clk_in = ~clk_in;
  thcm_hand_model sw (.act1_in(a1), .act2_in(a2), .wrong1_in(w1), .wrong2_in(w2),
    .no1_out(n1), .nc1_out(c1), .no2_out(n2), .nc2_out(c2));
  thcm_two_hand #(.TICK_CYCLES(TICK)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .hand1_no_in(n1), .hand1_nc_in(c1), .hand2_no_in(n2), .hand2_nc_in(c2),
    .enable_out(en), .disc_err1_out(e1), .disc_err2_out(e2), .fault_out(flt),
    .irq_out(irq), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one single AHB transfer, waiting on hready in both phases
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_in); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hrdy !== 1'h1);
    q = hrdata;
  endtask
  // hold a contact pattern for n evaluation steps, then let outputs land
  task automatic hands(input logic [3:0] p, input int n);
    @(posedge clk_in);
    {a1, w1, a2, w2} <= p;
    repeat (n * TICK + 2) @(posedge clk_in);
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under two thousand clocks
  initial begin
    repeat (6000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'h0;
    bus(1'h0, thcm_pkg::OFF_CTRL, 32'h0);
    chk(q, 32'hF);
    bus(1'h0, thcm_pkg::OFF_DISC1, 32'h0);
    chk(q, 32'h3);
    bus(1'h0, 12'h0FC, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, thcm_pkg::OFF_DISC2, 32'h3F);
    bus(1'h0, thcm_pkg::OFF_DISC2, 32'h0);
    chk(q, 32'h32);
    bus(1'h1, thcm_pkg::OFF_DISC2, 32'h0);
    bus(1'h1, thcm_pkg::OFF_DISC1, 32'h2);
    // full truth table, each row entered from a release
    for (int i = 0; i < 16; i++) begin
      hands(4'h0, 2);
      hands(rows[i][4:1], 1); // one step: at most two evaluations, below the limit
      chk(32'(en), 32'(rows[i][0]));
      chk(32'({e1, e2}), 32'h0);
    end
    // both pairs disagree: pair one trips after its limit, pair two never
    hands(4'hA, 2);
    chk(32'(en), 32'h1);
    hands(4'hF, 1);
    chk(32'(e1), 32'h0);
    hands(4'hF, 4);
    chk(32'({en, e1, e2, flt}), 32'h5);
    chk(32'(irq), 32'h0);
    bus(1'h1, thcm_pkg::OFF_IRQ_EN, 32'h1);
    settle();
    chk(32'(irq), 32'h1);
    bus(1'h0, thcm_pkg::OFF_IRQ_STAT, 32'h0);
    chk(32'(q[0]), 32'h1);
    bus(1'h1, thcm_pkg::OFF_IRQ_CLR, 32'hF);
    settle();
    chk(32'(irq), 32'h0);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'h5);
    settle();
    chk(32'({e1, flt}), 32'h0);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'hF);
    // error survives a plain press, clears on release then press
    hands(4'hA, 1);
    chk(32'(e1), 32'h1);
    hands(4'h0, 1);
    hands(4'hA, 1);
    chk(32'({e1, en}), 32'h0);
    hands(4'h0, 1);
    hands(4'hA, 1);
    chk(32'(en), 32'h1);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'hE);
    settle();
    chk(32'(en), 32'h0);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'hF);
    // second error, cleared by idle then run
    hands(4'hF, 4);
    hands(4'h0, 1);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'hE);
    bus(1'h1, thcm_pkg::OFF_CTRL, 32'hF);
    settle();
    chk(32'(e1), 32'h0);
    // second hand late: inside and outside the window
    hands(4'h0, 1);
    hands(4'h8, 47);
    hands(4'hA, 1);
    chk(32'(en), 32'h1);
    bus(1'h0, thcm_pkg::OFF_IRQ_STAT, 32'h0);
    chk(32'(q[3]), 32'h0);
    hands(4'h0, 2);
    hands(4'h8, 53);
    hands(4'hA, 1);
    chk(32'({en, e1, e2}), 32'h0);
    bus(1'h0, thcm_pkg::OFF_IRQ_STAT, 32'h0);
    chk(32'(q[3]), 32'h1);
    // mid-run reset with both hands held: defaults back, no enable without release
    @(posedge clk_in);
    rst_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    hands(4'hA, 2);
    chk(32'({en, e1, e2, flt, irq}), 32'h0);
    bus(1'h0, thcm_pkg::OFF_DISC1, 32'h0);
    chk(q, 32'h3);
    chk(32'(hresp), 32'h0);
    // pair two back at its default limit trips on the fourth step
    hands(4'h1, 4);
    chk(32'({e1, e2, flt}), 32'h3);
    end_sim();
  end
endmodule
`default_nettype wire
